// [inc/lcs_regs.svh]
// Register offsets, field positions and reset values of the control generator
`ifndef LCS_REGS_SVH
`define LCS_REGS_SVH

`define LCS_ADDR_W        3
`define LCS_DATA_W        32
`define LCS_ADDR_CLK      3'h0
`define LCS_ADDR_CTL      3'h1
`define LCS_ADDR_CELL     3'h2
`define LCS_ADDR_PAD      3'h3
`define LCS_ADDR_LOAD     3'h4
`define LCS_ADDR_STAT     3'h5

`define LCS_N_COL         4
`define LCS_N_LOCAL       4
`define LCS_N_SRC         8
`define LCS_SEL_W         3
`define LCS_N_CTL         8
`define LCS_CLK_FLD_W     4

`define LCS_RST_CLK       8'h10
`define LCS_RST_CTL       24'hfbeb64
`define LCS_RST_CELL      32'h00000000
`define LCS_RST_PAD       24'h000000
`define LCS_RST_LOAD      32'h00000000

`define LCS_CELL_ACLR_LSB 16
`define LCS_LOAD_SDAT_LSB 16
`define LCS_PAD_UNUSED_LSB 8
`define LCS_PAD_GND_LSB   16
`define LCS_STAT_DUAL_BIT 16
`define LCS_STAT_PADI_LSB 24

`endif

// [inc/lcs_pkg.sv]
// Types shared by the control generator and its cells
package lcs_pkg;

   // Clock selector: source index and edge polarity
   typedef struct packed {
      logic       fall;
      logic [2:0] sel;
   } lcs_clk_cfg_t;

   // The eight non-clock group controls, one bit each
   typedef struct packed {
      logic addnsub;
      logic sload;
      logic aload;
      logic sclr;
      logic aclr2;
      logic aclr1;
      logic ena2;
      logic ena1;
   } lcs_ctl_t;

   // Controls as seen by one cell after clock and clear selection
   typedef struct packed {
      logic aclr;
      logic aload;
      logic aload_data;
      logic tick;
      logic sclr;
      logic sload;
      logic sload_data;
      logic sub;
   } lcs_cell_ctl_t;

endpackage

// [src/lcs_cell.sv]
// One logic element cell: adder/subtractor bit with its register
module lcs_cell (
   input  wire logic                  clk_sys_in,
   input  wire logic                  rst_in,
   input  wire lcs_pkg::lcs_cell_ctl_t ctl_in,
   input  wire logic                  a_in,
   input  wire logic                  b_in,
   input  wire logic                  carry_in,
   output logic                       carry_out,
   output logic                       q_out
);
   logic q_q;
   logic q_d;
   logic b_eff;
   logic sum;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   // add or subtract: subtract inverts b, carry-in supplies the one
   always_comb begin
      b_eff     = b_in ^ ctl_in.sub;
      sum       = a_in ^ b_eff ^ carry_in;
      carry_out = (a_in & b_eff) | (carry_in & (a_in ^ b_eff));
   end

   // priority: async clear, async load, sync clear, sync load
   always_comb begin
      q_d = q_q;
      if (ctl_in.aclr) begin
         q_d = 1'b0;
      end else if (ctl_in.aload) begin
         // preset is an async load with the load data high
         q_d = ctl_in.aload_data;
      end else if (ctl_in.tick) begin
         if (ctl_in.sclr) begin
            q_d = 1'b0;
         end else if (ctl_in.sload) begin
            q_d = ctl_in.sload_data;
         end else begin
            q_d = sum;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         q_q <= 1'b0;
      end else begin
         q_q <= q_d;
      end
   end

   assign q_out = q_q;

   clear_wins_a: assert property (ctl_in.aclr |=> !q_out)
      else $error("async clear did not clear the cell");
   preset_load_a: assert property (
      ctl_in.aload && !ctl_in.aclr |=> q_out == $past(ctl_in.aload_data))
      else $error("async load did not take its data");
   held_idle_a: assert property (
      !ctl_in.aclr && !ctl_in.aload && !ctl_in.tick |=> $stable(q_out))
      else $error("cell changed without a gated clock");

endmodule // lcs_cell

// [src/lcs_pad.sv]
// One I/O pad with open-drain and unused-pin options
module lcs_pad (
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   input  wire logic val_in,
   input  wire logic open_drain_in,
   input  wire logic unused_in,
   input  wire logic gnd_mode_in,
   output logic      o_out,
   output logic      oe_out
);
   logic o_q;
   logic o_d;
   logic oe_q;
   logic oe_d;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   // Unused pin first, then open drain, then normal push-pull drive
   always_comb begin
      o_d  = 1'b0;
      oe_d = 1'b0;
      if (unused_in) begin
         oe_d = gnd_mode_in;
      end else if (open_drain_in) begin
         // open drain: pull low or release
         oe_d = ~val_in;
      end else begin
         o_d  = val_in;
         oe_d = 1'b1;
      end
   end

   // Pad released during reset so shared lines are not disturbed
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         o_q  <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         o_q  <= o_d;
         oe_q <= oe_d;
      end
   end

   assign o_out  = o_q;
   assign oe_out = oe_q;

   open_drain_a: assert property (
      !unused_in && open_drain_in |=> !o_out && oe_out == !$past(val_in))
      else $error("open drain pad drove high");
   unused_pin_a: assert property (
      unused_in |=> !o_out && oe_out == $past(gnd_mode_in))
      else $error("unused pad in wrong state");

endmodule // lcs_pad

// [src/lcs_control_gen.sv]
// Group control signal generator with cells, pads and register port
//
// Chosen here: strobed register access and the register addresses.
`include "lcs_regs.svh"

// Functional notes
// - At most ten group controls at once
// - Each group clock tied to its enable
// - Both edges needed consume both clocks
// - Enable low stops its group clock
// - Two async clears, async load presets
// - One add/subtract select shared by all cells
// - Controls from column clocks or local lines
// - Pads optionally open drain, pull low
// - Unused pads ground or tri-stated input
module lcs_control_gen #(
   parameter int N_CELLS = 10,
   parameter int N_PADS  = 4
) (
   input  wire logic                   clk_sys_in,
   input  wire logic                   rst_in,
   input  wire logic [`LCS_N_COL-1:0]  col_clk_in,
   input  wire logic [`LCS_N_LOCAL-1:0] local_ctl_in,
   input  wire logic [N_CELLS-1:0]     data_a_in,
   input  wire logic [N_CELLS-1:0]     data_b_in,
   input  wire logic [N_PADS-1:0]      pad_i_in,
   input  wire logic [`LCS_ADDR_W-1:0] reg_addr_in,
   input  wire logic [`LCS_DATA_W-1:0] reg_wdata_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   output logic [`LCS_DATA_W-1:0]      reg_rdata_out,
   output logic [N_CELLS-1:0]          cell_q_out,
   output logic [N_PADS-1:0]           pad_o_out,
   output logic [N_PADS-1:0]           pad_oe_out
);
   localparam int CTL_W = `LCS_N_CTL * `LCS_SEL_W;

   // Configuration registers
   logic [2*`LCS_CLK_FLD_W-1:0] clk_cfg_q;
   logic [2*`LCS_CLK_FLD_W-1:0] clk_cfg_d;
   logic [CTL_W-1:0]            ctl_cfg_q;
   logic [CTL_W-1:0]            ctl_cfg_d;
   logic [`LCS_DATA_W-1:0]      cell_cfg_q;
   logic [`LCS_DATA_W-1:0]      cell_cfg_d;
   logic [CTL_W-1:0]            pad_cfg_q;
   logic [CTL_W-1:0]            pad_cfg_d;
   logic [`LCS_DATA_W-1:0]      load_q;
   logic [`LCS_DATA_W-1:0]      load_d;
   logic [`LCS_DATA_W-1:0]      rdata_q;
   logic [`LCS_DATA_W-1:0]      rdata_d;

   // Sampled sources and their previous values
   logic [`LCS_N_SRC-1:0]       src_q;
   logic [`LCS_N_SRC-1:0]       src_d;
   logic [`LCS_N_SRC-1:0]       src_prev_q;

   lcs_pkg::lcs_clk_cfg_t       clk1_cfg;
   lcs_pkg::lcs_clk_cfg_t       clk2_cfg;
   lcs_pkg::lcs_ctl_t           ctl;
   logic                        tick1;
   logic                        tick2;
   logic                        gtick1;
   logic                        gtick2;
   logic                        dual_edge;
   logic [N_CELLS:0]            carry;
   logic [N_CELLS-1:0]          cell_q;
   logic [N_CELLS-1:0]          pad_src;

   // Register writes; unmapped offsets are ignored
   always_comb begin
      clk_cfg_d  = clk_cfg_q;
      ctl_cfg_d  = ctl_cfg_q;
      cell_cfg_d = cell_cfg_q;
      pad_cfg_d  = pad_cfg_q;
      load_d     = load_q;
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            `LCS_ADDR_CLK:  clk_cfg_d  = reg_wdata_in[2*`LCS_CLK_FLD_W-1:0];
            `LCS_ADDR_CTL:  ctl_cfg_d  = reg_wdata_in[CTL_W-1:0];
            `LCS_ADDR_CELL: cell_cfg_d = reg_wdata_in;
            `LCS_ADDR_PAD:  pad_cfg_d  = reg_wdata_in[CTL_W-1:0];
            `LCS_ADDR_LOAD: load_d     = reg_wdata_in;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         clk_cfg_q  <= `LCS_RST_CLK;
         ctl_cfg_q  <= `LCS_RST_CTL;
         cell_cfg_q <= `LCS_RST_CELL;
         pad_cfg_q  <= `LCS_RST_PAD;
         load_q     <= `LCS_RST_LOAD;
      end else begin
         clk_cfg_q  <= clk_cfg_d;
         ctl_cfg_q  <= ctl_cfg_d;
         cell_cfg_q <= cell_cfg_d;
         pad_cfg_q  <= pad_cfg_d;
         load_q     <= load_d;
      end
   end

   // sources: column clocks low, local lines high
   always_comb begin
      src_d = {local_ctl_in, col_clk_in};
   end

   // Edges are seen one cycle after sampling, so every source lags equally
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         src_q      <= '0;
         src_prev_q <= '0;
      end else begin
         src_q      <= src_d;
         src_prev_q <= src_q;
      end
   end

   // eight controls plus two clocks make ten
   genvar k;
   generate
      for (k = 0; k < `LCS_N_CTL; k++) begin : g_ctl
         assign ctl[k] = src_q[ctl_cfg_q[k*`LCS_SEL_W +: `LCS_SEL_W]];
      end
   endgenerate

   // clock events from the selected source edge
   always_comb begin
      clk1_cfg = lcs_pkg::lcs_clk_cfg_t'(clk_cfg_q[`LCS_CLK_FLD_W-1:0]);
      clk2_cfg = lcs_pkg::lcs_clk_cfg_t'(
                    clk_cfg_q[2*`LCS_CLK_FLD_W-1:`LCS_CLK_FLD_W]);
      tick1 = clk1_cfg.fall
            ? (src_prev_q[clk1_cfg.sel] & ~src_q[clk1_cfg.sel])
            : (src_q[clk1_cfg.sel] & ~src_prev_q[clk1_cfg.sel]);
      tick2 = clk2_cfg.fall
            ? (src_prev_q[clk2_cfg.sel] & ~src_q[clk2_cfg.sel])
            : (src_q[clk2_cfg.sel] & ~src_prev_q[clk2_cfg.sel]);
   end

   // gated clocks: enable low removes every event
   always_comb begin
      // pairing: clock one with enable one, two with two
      gtick1 = tick1 & ctl.ena1;
      gtick2 = tick2 & ctl.ena2;
   end

   // both edges of one source use both group clocks
   always_comb begin
      dual_edge = (clk1_cfg.sel == clk2_cfg.sel) &&
                  (clk1_cfg.fall != clk2_cfg.fall);
   end

   // Carry chain starts with the subtract bit for two's complement
   assign carry[0] = ctl.addnsub;

   // One cell per element; cell config picks clock and clear line
   genvar i;
   generate
      for (i = 0; i < N_CELLS; i++) begin : g_cell
         lcs_pkg::lcs_cell_ctl_t cctl;
         // cell clocked by clock two uses only enable two
         // each cell picks one of the two async clears
         always_comb begin
            cctl.aclr       = cell_cfg_q[`LCS_CELL_ACLR_LSB + i]
                            ? ctl.aclr2 : ctl.aclr1;
            cctl.aload      = ctl.aload;
            cctl.aload_data = load_q[i];
            cctl.tick       = cell_cfg_q[i] ? gtick2 : gtick1;
            cctl.sclr       = ctl.sclr;
            cctl.sload      = ctl.sload;
            cctl.sload_data = load_q[`LCS_LOAD_SDAT_LSB + i];
            // one select shared by all cells
            cctl.sub        = ctl.addnsub;
         end
         lcs_cell u_cell (
            .clk_sys_in (clk_sys_in),
            .rst_in     (rst_in),
            .ctl_in     (cctl),
            .a_in       (data_a_in[i]),
            .b_in       (data_b_in[i]),
            .carry_in   (carry[i]),
            .carry_out  (carry[i+1]),
            .q_out      (cell_q[i])
         );
      end
   endgenerate

   assign cell_q_out = cell_q;
   assign pad_src    = cell_q;

   // each pad driven by a cell, modes from the pad register
   genvar p;
   generate
      for (p = 0; p < N_PADS; p++) begin : g_pad
         lcs_pad u_pad (
            .clk_sys_in    (clk_sys_in),
            .rst_in        (rst_in),
            .val_in        (pad_src[p % N_CELLS]),
            .open_drain_in (pad_cfg_q[p]),
            .unused_in     (pad_cfg_q[`LCS_PAD_UNUSED_LSB + p]),
            .gnd_mode_in   (pad_cfg_q[`LCS_PAD_GND_LSB + p]),
            .o_out         (pad_o_out[p]),
            .oe_out        (pad_oe_out[p])
         );
      end
   endgenerate

   // Read data valid only in the cycle after the strobe
   always_comb begin
      rdata_d = '0;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            `LCS_ADDR_CLK:  rdata_d[2*`LCS_CLK_FLD_W-1:0] = clk_cfg_q;
            `LCS_ADDR_CTL:  rdata_d[CTL_W-1:0] = ctl_cfg_q;
            `LCS_ADDR_CELL: rdata_d = cell_cfg_q;
            `LCS_ADDR_PAD:  rdata_d[CTL_W-1:0] = pad_cfg_q;
            `LCS_ADDR_LOAD: rdata_d = load_q;
            `LCS_ADDR_STAT: begin
               rdata_d[N_CELLS-1:0] = cell_q;
               // status shows that both clocks are spent
               rdata_d[`LCS_STAT_DUAL_BIT] = dual_edge;
               rdata_d[`LCS_STAT_PADI_LSB +: N_PADS] = pad_i_in;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;

   // Helper terms for the checks below
   logic       calm01;
   logic [1:0] exp01;
   always_comb begin
      calm01 = gtick1 && (cell_cfg_q[1:0] == 2'b00) && !ctl.aclr1 &&
               !ctl.aclr2 && !ctl.aload && !ctl.sclr && !ctl.sload;
      exp01  = ctl.addnsub ? (data_a_in[1:0] - data_b_in[1:0])
                           : (data_a_in[1:0] + data_b_in[1:0]);
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   rise_tick_a: assert property (
      !clk1_cfg.fall && $rose(src_q[clk1_cfg.sel]) && $stable(clk_cfg_q)
      |-> tick1)
      else $error("rising source edge gave no clock event");
   // A cell on clock two must ignore enable one entirely
   enable_pair_a: assert property (
      cell_cfg_q[0] && !ctl.ena2 && !ctl.aclr1 && !ctl.aclr2 &&
      !ctl.aload |=> $stable(cell_q_out[0]))
      else $error("clock two cell updated with enable two low");
   enable_stop_a: assert property (
      !ctl.ena1 && (cell_cfg_q[0] == 1'b0) && !ctl.aclr1 &&
      !ctl.aclr2 && !ctl.aload |=> $stable(cell_q_out[0]))
      else $error("cell updated with its enable low");
   dual_flag_a: assert property (
      reg_rd_in && reg_addr_in == `LCS_ADDR_STAT
      |=> reg_rdata_out[`LCS_STAT_DUAL_BIT] == $past(dual_edge))
      else $error("both-edge status wrong");
   add_sub_a: assert property (
      calm01 |=> cell_q_out[1:0] == $past(exp01))
      else $error("two-bit add or subtract gave wrong result");
   read_once_a: assert property (
      !reg_rd_in |=> reg_rdata_out == '0)
      else $error("read data present without a read");

   // Falling events matter when both edges of one source are in use
   fall_tick_a: assert property (
      clk2_cfg.fall && $fell(src_q[clk2_cfg.sel]) && $stable(clk_cfg_q)
      |-> tick2)
      else $error("falling source edge gave no clock event");

   // Priority among the cell controls, seen from the group outputs
   sclr_wins_a: assert property (
      gtick1 && ctl.sclr && ctl.sload && !ctl.aclr1 && !ctl.aclr2 &&
      !ctl.aload && (cell_cfg_q[0] == 1'b0) |=> !cell_q_out[0])
      else $error("sync load beat sync clear");
   aload_wins_a: assert property (
      ctl.aload && !ctl.aclr1 && !ctl.aclr2
      |=> cell_q_out == $past(load_q[N_CELLS-1:0]))
      else $error("async load did not win over sync controls");
   aclr_line_a: assert property (
      ctl.aclr2 && cell_cfg_q[`LCS_CELL_ACLR_LSB] |=> !cell_q_out[0])
      else $error("second clear line missed its cell");

   // Pads follow their cells one cycle later
   pad_follow_a: assert property (
      !pad_cfg_q[0] && !pad_cfg_q[`LCS_PAD_UNUSED_LSB]
      |=> pad_oe_out[0] && pad_o_out[0] == $past(cell_q[0]))
      else $error("push-pull pad did not follow its cell");
   pad_od_low_a: assert property (
      pad_cfg_q[1] && !pad_cfg_q[`LCS_PAD_UNUSED_LSB + 1] && !cell_q[1]
      |=> pad_oe_out[1] && !pad_o_out[1])
      else $error("open drain pad did not pull low");

endmodule // lcs_control_gen

// [test/lcs_wired_line.sv]
// Partner model: shared pull-up control lines on the group's pads
module lcs_wired_line #(
   parameter int N = 4
) (
   input  wire logic [N-1:0] pad_o_in,
   input  wire logic [N-1:0] pad_oe_in,
   input  wire logic [N-1:0] pull_low_in,
   output logic      [N-1:0] line_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // Resolve each line; released lines float high, never hold a stale value
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (pull_low_in[i] || (pad_oe_in[i] && !pad_o_in[i])) begin
            line_out[i] = 1'b0;
         end else begin
            line_out[i] = 1'b1;
         end
      end
   end
endmodule // lcs_wired_line

// [test/testbench.sv]
// Self-checking bench for the group control generator
`include "lcs_regs.svh"

module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_sys_in = 1'b0;
   logic        rst_in     = 1'b1;
   logic [3:0]  col_clk    = 4'h0;
   logic [3:0]  local_ctl  = 4'h0;
   logic [9:0]  data_a     = 10'h000;
   logic [9:0]  data_b     = 10'h000;
   logic [2:0]  addr       = 3'h0;
   logic [31:0] wdata      = 32'h00000000;
   logic        wr         = 1'b0;
   logic        rd         = 1'b0;
   logic [3:0]  other_low  = 4'h0;
   logic [31:0] rdata;
   logic [9:0]  cell_q;
   logic [3:0]  pad_o;
   logic [3:0]  pad_oe;
   logic [3:0]  pad_i;
   int          num_errors = 0;
   int          num_checks = 0;
   int          cycles     = 0;

   // 40 MHz system clock
   initial begin
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end

   lcs_control_gen #(.N_CELLS(10), .N_PADS(4)) dut (
      .clk_sys_in    (clk_sys_in),
      .rst_in        (rst_in),
      .col_clk_in    (col_clk),
      .local_ctl_in  (local_ctl),
      .data_a_in     (data_a),
      .data_b_in     (data_b),
      .pad_i_in      (pad_i),
      .reg_addr_in   (addr),
      .reg_wdata_in  (wdata),
      .reg_wr_in     (wr),
      .reg_rd_in     (rd),
      .reg_rdata_out (rdata),
      .cell_q_out    (cell_q),
      .pad_o_out     (pad_o),
      .pad_oe_out    (pad_oe)
   );

   lcs_wired_line #(.N(4)) line_model (
      .pad_o_in    (pad_o),
      .pad_oe_in   (pad_oe),
      .pull_low_in (other_low),
      .line_out    (pad_i)
   );

   // Verdict and end of run, shared by main sequence and timeout
   task automatic conclude();
      if (num_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [2:0] a, input logic [31:0] exp,
                         input logic [31:0] mask);
      @(posedge clk_sys_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      @(negedge clk_sys_in);
      check(rdata & mask, exp);
   endtask

   // Control levels pass a two-stage path, so three cycles is ample
   task automatic drive(input logic [9:0] a, input logic [9:0] b,
                        input logic [3:0] loc, input logic [3:0] col);
      @(posedge clk_sys_in);
      data_a    <= a;
      data_b    <= b;
      local_ctl <= loc;
      col_clk   <= col;
      repeat (3) @(posedge clk_sys_in);
   endtask

   // One full period of column clock zero, then look at the cells
   task automatic pulse(input logic [9:0] a, input logic [9:0] b,
                        input logic [3:0] loc, input logic [3:0] col,
                        input logic [9:0] exp);
      drive(a, b, loc, col | 4'h1);
      drive(a, b, loc, col & 4'he);
      @(negedge clk_sys_in);
      check({22'h000000, cell_q}, {22'h000000, exp});
   endtask

   // Hang guard: the sequence needs well under a thousand cycles
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         conclude();
      end
   end

   initial begin
      repeat (6) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      reg_rd(`LCS_ADDR_CLK, 32'h00000010, 32'hffffffff);
      reg_rd(`LCS_ADDR_CTL, 32'h00fbeb64, 32'hffffffff);
      reg_rd(`LCS_ADDR_CELL, 32'h00000000, 32'hffffffff);
      reg_rd(`LCS_ADDR_PAD, 32'h00000000, 32'hffffffff);
      reg_rd(`LCS_ADDR_LOAD, 32'h00000000, 32'hffffffff);
      reg_wr(3'h6, 32'hffffffff);
      reg_rd(3'h6, 32'h00000000, 32'hffffffff);
      reg_rd(3'h7, 32'h00000000, 32'hffffffff);
      // Enable local0, clears local1/col1, sclr local2, aload local3,
      // sload col2, add/subtract col3
      reg_wr(`LCS_ADDR_CTL, 32'h006be364);
      reg_rd(`LCS_ADDR_CTL, 32'h006be364, 32'hffffffff);
      pulse(10'h155, 10'h0ab, 4'h1, 4'h0, 10'h200);
      pulse(10'h100, 10'h001, 4'h1, 4'h8, 10'h0ff);
      pulse(10'h3ff, 10'h000, 4'h0, 4'h0, 10'h0ff);
      reg_wr(`LCS_ADDR_LOAD, 32'h02a50133);
      pulse(10'h3ff, 10'h000, 4'h1, 4'h4, 10'h2a5);
      pulse(10'h000, 10'h000, 4'h4, 4'h4, 10'h2a5);
      pulse(10'h000, 10'h000, 4'h5, 4'h4, 10'h000);
      // Asynchronous controls act with no column clock edge at all
      // Sample away from the edge that updates the cells
      drive(10'h000, 10'h000, 4'h8, 4'h0);
      @(negedge clk_sys_in);
      check({22'h000000, cell_q}, 32'h00000133);
      drive(10'h000, 10'h000, 4'ha, 4'h0);
      @(negedge clk_sys_in);
      check({22'h000000, cell_q}, 32'h00000000);
      drive(10'h000, 10'h000, 4'h8, 4'h0);
      drive(10'h000, 10'h000, 4'h0, 4'h0);
      // Pad0 push-pull, pad1 open drain, pad2 ground, pad3 tri-stated
      reg_wr(`LCS_ADDR_PAD, 32'h00040c02);
      drive(10'h000, 10'h000, 4'h0, 4'h0);
      @(negedge clk_sys_in);
      check({24'h000000, pad_oe, pad_o}, 32'h00000051);
      reg_rd(`LCS_ADDR_STAT, 32'h0b000133, 32'hffffffff);
      @(posedge clk_sys_in);
      other_low <= 4'h2;
      drive(10'h000, 10'h000, 4'h0, 4'h0);
      reg_rd(`LCS_ADDR_STAT, 32'h09000133, 32'hffffffff);
      // Second clear line reaches only cells 0..3
      reg_wr(`LCS_ADDR_CELL, 32'h000f0000);
      drive(10'h000, 10'h000, 4'h0, 4'h2);
      @(negedge clk_sys_in);
      check({22'h000000, cell_q}, 32'h00000130);
      // Cells 0 and 1 low now: the open-drain pad pulls its line low
      check({24'h000000, pad_oe, pad_o}, 32'h00000070);
      reg_rd(`LCS_ADDR_STAT, 32'h08000130, 32'hffffffff);
      // Cell 0 on clock two, falling edge of the same column clock
      reg_wr(`LCS_ADDR_CELL, 32'h00000001);
      reg_wr(`LCS_ADDR_CLK, 32'h00000080);
      reg_rd(`LCS_ADDR_STAT, 32'h00010000, 32'h00010000);
      drive(10'h3ff, 10'h000, 4'h1, 4'h1);
      @(negedge clk_sys_in);
      check({22'h000000, cell_q}, 32'h000003fe);
      drive(10'h3ff, 10'h000, 4'h1, 4'h0);
      @(negedge clk_sys_in);
      check({22'h000000, cell_q}, 32'h000003ff);
      conclude();
   end
endmodule // testbench
